// file: include/spu_map.vh
`ifndef SPU_MAP_VH
`define SPU_MAP_VH
// ==========================================
// Clock and time units
`define SPU_CLK_HZ 40000000
`define SPU_CLK_NS 25
`define SPU_UNIT_NS 625
// 625 ns in 25 ns clocks, sized so cycle products stay 16 bits
`define SPU_UNIT_CYC 8'h19
// ==========================================
// Baud rates, select codes 0..6
`define SPU_BAUD0 9600
`define SPU_BAUD1 14400
`define SPU_BAUD2 19200
`define SPU_BAUD3 28800
`define SPU_BAUD4 38400
`define SPU_BAUD5 57600
`define SPU_BAUD6 76800
`define SPU_BR_SEL_MAX 8'h06
// Power-on divisor, 9600 baud at 40 MHz
`define SPU_DIV_RST 16'h1047
// ==========================================
// Commands and replies
`define SPU_CMD_BR 8'h02
`define SPU_CMD_INIT 8'h04
`define SPU_CMD_CTRL 8'h05
`define SPU_RSP_ACK 8'h00
`define SPU_RSP_NAK 8'hff
`define SPU_LEN_BR 3'h1
`define SPU_LEN_INIT 3'h6
`define SPU_LEN_CTRL 3'h3
// ==========================================
// Initialization register fields and reset value
`define SPU_F_CFS 12:0
`define SPU_F_FRS 15:13
`define SPU_F_PDY 23:16
`define SPU_F_PDT 31:24
`define SPU_INIT_RST 48'h0000_0804_3000
`define SPU_CFS_MIN 13'h0019
`define SPU_CFS_MAX 13'h1400
// ==========================================
// Control register fields
`define SPU_F_PFS 12:0
`define SPU_B_INH_N 15
`define SPU_F_AMP 23:16
`define SPU_CTRL_RST 24'h00_0000
// ==========================================
// Modes and accumulator moduli
`define SPU_MODE_UART 3'h2
`define SPU_MODE_GRID_UART 3'h6
`define SPU_CAR_MOD 23'h7d_0000
`define SPU_CAR_HALF 23'h3e_8000
`define SPU_POW_MOD 23'h30_0000
`define SPU_POW_HALF 22'h18_0000
// Full power periods at 50 and 60 Hz, in clocks
`define SPU_FIX50_CYC 20'hc3500
`define SPU_FIX60_CYC 20'ha2c2a
`endif

// file: hdl/spu_uart_rx.v
`timescale 1ns/1ps
`default_nettype none
module spu_uart_rx (
  input wire clk_i,
  input wire sys_rst_i,
  input wire rxd_i,
  input wire [15:0] div_i,
  output reg [7:0] data_o,
  output reg valid_o
);
  reg s0_q, s1_q;
  reg busy_q;
  reg [15:0] cnt_q;
  reg [3:0] bit_q;
  reg [8:0] sh_q;
  // ==========================================
  // Two-stage input sync, then mid-bit sampling
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s0_q <= 1'b1;
      s1_q <= 1'b1;
      busy_q <= 1'b0;
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
      data_o <= 8'h00;
      valid_o <= 1'b0;
    end else begin
      s0_q <= rxd_i;
      s1_q <= s0_q;
      valid_o <= 1'b0;
      if (!busy_q) begin
        if (!s1_q) begin
          busy_q <= 1'b1;
          cnt_q <= {1'b0, div_i[15:1]};
          bit_q <= 4'h0;
        end
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        cnt_q <= div_i - 16'h0001;
        bit_q <= bit_q + 4'h1;
        sh_q <= {s1_q, sh_q[8:1]};
        if (bit_q == 4'h0 && s1_q) begin
          // Glitch, not a start bit
          busy_q <= 1'b0;
        end else if (bit_q == 4'h9) begin
          busy_q <= 1'b0;
          // Bad stop bit drops the character
          if (s1_q) begin
            data_o <= sh_q[8:1];
            valid_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule // spu_uart_rx
`default_nettype wire

// file: hdl/spu_uart_tx.v
`timescale 1ns/1ps
`default_nettype none
module spu_uart_tx (
  input wire clk_i,
  input wire sys_rst_i,
  input wire start_i,
  input wire [7:0] data_i,
  input wire [15:0] div_i,
  output wire busy_o,
  output reg txd_o
);
  reg busy_q;
  reg [15:0] cnt_q;
  reg [3:0] bit_q;
  reg [9:0] sh_q;
  assign busy_o = busy_q | start_i;
  // ==========================================
  // Start, eight data LSB first, stop
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q <= 10'h3ff;
      txd_o <= 1'b1;
    end else if (!busy_q) begin
      txd_o <= 1'b1;
      if (start_i) begin
        busy_q <= 1'b1;
        sh_q <= {1'b1, data_i, 1'b0};
        cnt_q <= 16'h0000;
        bit_q <= 4'h0;
      end
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else if (bit_q == 4'ha) begin
      busy_q <= 1'b0;
    end else begin
      txd_o <= sh_q[0];
      sh_q <= {1'b1, sh_q[9:1]};
      bit_q <= bit_q + 4'h1;
      cnt_q <= div_i - 16'h0001;
    end
  end
endmodule // spu_uart_tx
`default_nettype wire

// file: hdl/spu_pwm_top.v
// Functional notes
// - Trip input shuts all switches off three clocks later (2FF sync plus output flop)
// - Seven baud rates, 9600 after power-on
// - Start, eight data, stop: ten bits
// - Command, data, checksum; eight bytes maximum
// - Checksum is 8-bit sum, carries dropped
// - Checksum verified before block takes effect
// - Mode pins pick frequency source
// - Power frequency writes ignored outside modes 2,6
// - 48-bit init and 24-bit control registers
// - Saved init parameters loaded at power-up
// - Init accepted anytime, outputs active or not
// - Complementary leg switches with dead interval
// - Six staging bytes, then one transfer
// - Carrier select 13 bits, range shares byte1
// - Carrier 10000*cfs/2048, cfs clamped 25..5120
// - Range codes 0..5 give multiplier 1..32
// - Range is carrier/384 times multiplier
// - Outside fixed 50/60 Hz modes, power frequency never exceeds the range
// - Underlap delays every rising edge equally
// - Pulses shorter than minimum width removed
// - Minimum width set by 8-bit deletion word
// - Write commands answered ACK/NAK plus checksum
`timescale 1ns/1ps
`default_nettype none
`include "spu_map.vh"
module spu_pwm_top (
  input wire clk_i,
  input wire sys_rst_i,
  input wire counter_rst_n_i,
  input wire rxd_i,
  output wire txd_o,
  input wire set_trip_i,
  input wire mode_select_bit2_i,
  input wire mode_select_bit1_i,
  input wire mode_select_bit0_i,
  input wire nv_valid_i,
  input wire [47:0] nv_init_i,
  output reg left_top_switch_o,
  output reg left_bottom_switch_o,
  output reg right_top_switch_o,
  output reg right_bottom_switch_o,
  output reg trip_n_o,
  output reg output_status_o
);
  localparam ST_CMD = 4'b0001;
  localparam ST_DATA = 4'b0010;
  localparam ST_ACK = 4'b0100;
  localparam ST_CHK = 4'b1000;
  // ==========================================
  // Functions
  function [15:0] baud_div;
    input [2:0] sel;
    integer hz;
    integer q;
    begin
      case (sel)
        3'h1: hz = `SPU_BAUD1;
        3'h2: hz = `SPU_BAUD2;
        3'h3: hz = `SPU_BAUD3;
        3'h4: hz = `SPU_BAUD4;
        3'h5: hz = `SPU_BAUD5;
        3'h6: hz = `SPU_BAUD6;
        default: hz = `SPU_BAUD0;
      endcase
      q = (`SPU_CLK_HZ + hz / 2) / hz;
      baud_div = q[15:0];
    end
  endfunction
  function [15:0] to_cycles;
    input [7:0] word;
    begin
      to_cycles = word * `SPU_UNIT_CYC;
    end
  endfunction
  // ==========================================
  // Pin synchronisers
  reg trip0_q, trip1_q, run0_q, run1_q;
  reg [2:0] mode0_q, mode1_q;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trip0_q <= 1'b0;
      trip1_q <= 1'b0;
      run0_q <= 1'b0;
      run1_q <= 1'b0;
      mode0_q <= 3'h0;
      mode1_q <= 3'h0;
    end else begin
      trip0_q <= set_trip_i;
      trip1_q <= trip0_q;
      run0_q <= counter_rst_n_i;
      run1_q <= run0_q;
      mode0_q <= {mode_select_bit2_i, mode_select_bit1_i, mode_select_bit0_i};
      mode1_q <= mode0_q;
    end
  end
  // ==========================================
  // Serial link
  reg [15:0] div_q;
  reg tx_start_q;
  reg [7:0] tx_data_q;
  wire [7:0] rx_data;
  wire rx_valid, tx_busy;
  spu_uart_rx u_rx (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .rxd_i(rxd_i),
    .div_i(div_q),
    .data_o(rx_data),
    .valid_o(rx_valid)
  );
  spu_uart_tx u_tx (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(tx_start_q),
    .data_i(tx_data_q),
    .div_i(div_q),
    .busy_o(tx_busy),
    .txd_o(txd_o)
  );
  // ==========================================
  // Block parser and register loads
  reg [3:0] st_q;
  reg [7:0] cmd_q, sum_q, rsp_q;
  reg [2:0] cnt_q, len_q, br_sel_q;
  reg [7:0] stage_q [0:5];
  reg [47:0] init_q;
  reg [23:0] ctrl_q;
  reg nv_done_q, br_pend_q;
  wire uart_pfs = (mode1_q == `SPU_MODE_UART) || (mode1_q == `SPU_MODE_GRID_UART);
  wire sum_ok = (rx_data == sum_q);
  wire tx_free = !tx_busy && !tx_start_q;
  integer k;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_CMD;
      cmd_q <= 8'h00;
      sum_q <= 8'h00;
      cnt_q <= 3'h0;
      len_q <= 3'h0;
      rsp_q <= `SPU_RSP_NAK;
      init_q <= `SPU_INIT_RST;
      ctrl_q <= `SPU_CTRL_RST;
      nv_done_q <= 1'b0;
      br_pend_q <= 1'b0;
      br_sel_q <= 3'h0;
      div_q <= `SPU_DIV_RST;
      tx_start_q <= 1'b0;
      tx_data_q <= 8'h00;
      for (k = 0; k < 6; k = k + 1) begin
        stage_q[k] <= 8'h00;
      end
    end else begin
      tx_start_q <= 1'b0;
      nv_done_q <= 1'b1;
      if (!nv_done_q && nv_valid_i) begin
        init_q <= nv_init_i;
      end
      case (st_q)
        ST_CMD: begin
          // New rate only once the reply has left the wire
          if (br_pend_q && !tx_busy) begin
            br_pend_q <= 1'b0;
            div_q <= baud_div(br_sel_q);
          end
          if (rx_valid) begin
            cmd_q <= rx_data;
            sum_q <= rx_data;
            cnt_q <= 3'h0;
            st_q <= ST_DATA;
            case (rx_data)
              `SPU_CMD_BR: len_q <= `SPU_LEN_BR;
              `SPU_CMD_INIT: len_q <= `SPU_LEN_INIT;
              `SPU_CMD_CTRL: len_q <= `SPU_LEN_CTRL;
              default: begin
                rsp_q <= `SPU_RSP_NAK;
                st_q <= ST_ACK;
              end
            endcase
          end
        end
        ST_DATA: begin
          if (rx_valid) begin
            if (cnt_q == len_q) begin
              rsp_q <= sum_ok ? `SPU_RSP_ACK : `SPU_RSP_NAK;
              st_q <= ST_ACK;
              if (sum_ok) begin
                case (cmd_q)
                  `SPU_CMD_INIT: begin
                    init_q <= {stage_q[5], stage_q[4], stage_q[3],
                               stage_q[2], stage_q[1], stage_q[0]};
                  end
                  `SPU_CMD_CTRL: begin
                    ctrl_q[23:13] <= {stage_q[2], stage_q[1][7:5]};
                    if (uart_pfs) begin
                      ctrl_q[`SPU_F_PFS] <= {stage_q[1][4:0], stage_q[0]};
                    end
                  end
                  default: begin
                    if (stage_q[0] <= `SPU_BR_SEL_MAX) begin
                      br_pend_q <= 1'b1;
                      br_sel_q <= stage_q[0][2:0];
                    end else begin
                      rsp_q <= `SPU_RSP_NAK;
                    end
                  end
                endcase
              end
            end else begin
              stage_q[cnt_q] <= rx_data;
              sum_q <= sum_q + rx_data;
              cnt_q <= cnt_q + 3'h1;
            end
          end
        end
        ST_ACK: begin
          if (tx_free) begin
            tx_start_q <= 1'b1;
            tx_data_q <= rsp_q;
            st_q <= ST_CHK;
          end
        end
        ST_CHK: begin
          if (tx_free) begin
            tx_start_q <= 1'b1;
            tx_data_q <= rsp_q;
            st_q <= ST_CMD;
          end
        end
        default: st_q <= ST_CMD;
      endcase
    end
  end
  // ==========================================
  // Carrier and power-frequency phase
  wire [12:0] cfs_raw = init_q[`SPU_F_CFS];
  wire [12:0] cfs = (cfs_raw < `SPU_CFS_MIN) ? `SPU_CFS_MIN :
                    (cfs_raw > `SPU_CFS_MAX) ? `SPU_CFS_MAX : cfs_raw;
  wire [2:0] range_multiplier_select = init_q[`SPU_F_FRS];
  // Codes above 5 fall back to the top multiplier
  wire [5:0] mult = (range_multiplier_select > 3'h5) ? 6'h20 : (6'h01 << range_multiplier_select);
  reg [22:0] car_q;
  reg [21:0] pow_q;
  reg [19:0] fix_q;
  wire [22:0] car_sum = car_q + {10'h000, cfs};
  wire car_wrap = car_sum >= `SPU_CAR_MOD;
  // m*pfs per carrier period over 384*8192 keeps pfs a fraction of range
  wire [18:0] pow_step = mult * ctrl_q[`SPU_F_PFS];
  wire [22:0] pow_sum = {1'b0, pow_q} + {4'h0, pow_step};
  wire [22:0] pow_red = pow_sum - `SPU_POW_MOD;
  wire [19:0] fix_per = mode1_q[0] ? `SPU_FIX60_CYC : `SPU_FIX50_CYC;
  wire fixed_mode = !mode1_q[1];
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      car_q <= 23'h000000;
      pow_q <= 22'h000000;
      fix_q <= 20'h00000;
    end else if (!run1_q) begin
      car_q <= 23'h000000;
      pow_q <= 22'h000000;
      fix_q <= 20'h00000;
    end else begin
      car_q <= car_wrap ? car_sum - `SPU_CAR_MOD : car_sum;
      if (car_wrap) begin
        pow_q <= (pow_sum >= `SPU_POW_MOD) ? pow_red[21:0] : pow_sum[21:0];
      end
      fix_q <= (fix_q >= fix_per - 20'h00001) ? 20'h00000 : fix_q + 20'h00001;
    end
  end
  wire [22:0] tri_full = (car_q < `SPU_CAR_HALF) ? car_q : (`SPU_CAR_MOD - 23'h000001 - car_q);
  wire pwm = tri_full[21:14] < ctrl_q[`SPU_F_AMP];
  wire pol = fixed_mode ? (fix_q >= {1'b0, fix_per[19:1]}) : (pow_q >= `SPU_POW_HALF);
  wire [1:0] leg_raw = {~(pwm ^ pol), pwm ^ pol};
  // ==========================================
  // Pulse deletion and underlap per leg
  wire [15:0] del_cyc = to_cycles(init_q[`SPU_F_PDT]);
  wire [15:0] dly_cyc = to_cycles(init_q[`SPU_F_PDY]);
  wire [1:0] top_w, bot_w;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_leg
      reg [15:0] del_q, dly_q;
      reg filt_q, prev_q;
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          del_q <= 16'h0000;
          dly_q <= 16'h0000;
          filt_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          // Every edge is delayed equally, so surviving widths stay exact
          if (leg_raw[g] == filt_q) begin
            del_q <= 16'h0000;
          end else if (del_q + 16'h0001 >= del_cyc) begin
            filt_q <= leg_raw[g];
            del_q <= 16'h0000;
          end else begin
            del_q <= del_q + 16'h0001;
          end
          prev_q <= filt_q;
          if (filt_q != prev_q) begin
            dly_q <= dly_cyc;
          end else if (dly_q != 16'h0000) begin
            dly_q <= dly_q - 16'h0001;
          end
        end
      end
      // Both off while the leg changes over
      assign top_w[g] = filt_q && (filt_q == prev_q) && (dly_q == 16'h0000);
      assign bot_w[g] = !filt_q && (filt_q == prev_q) && (dly_q == 16'h0000);
    end
  endgenerate
  // ==========================================
  // Output stage
  // Inhibit sits after deletion, so a release may give one short pulse
  wire off = trip1_q || !run1_q || !ctrl_q[`SPU_B_INH_N];
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      left_top_switch_o <= 1'b0;
      left_bottom_switch_o <= 1'b0;
      right_top_switch_o <= 1'b0;
      right_bottom_switch_o <= 1'b0;
      trip_n_o <= 1'b1;
      output_status_o <= 1'b0;
    end else begin
      left_top_switch_o <= !off && top_w[0];
      left_bottom_switch_o <= !off && bot_w[0];
      right_top_switch_o <= !off && top_w[1];
      right_bottom_switch_o <= !off && bot_w[1];
      trip_n_o <= !trip1_q;
      output_status_o <= !off;
    end
  end
endmodule // spu_pwm_top
`default_nettype wire

// file: sim/spu_pwm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spu_pwm_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic set_trip_i,
  input wire logic txd_o,
  input wire logic left_top_switch_o,
  input wire logic left_bottom_switch_o,
  input wire logic right_top_switch_o,
  input wire logic right_bottom_switch_o,
  input wire logic trip_n_o,
  input wire logic output_status_o
);
  // ==========================================
  // Shared timing
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Four samples cover the 2FF sync plus the output flop
  sequence trip_held;
    set_trip_i [*4];
  endsequence
  sequence trip_gone;
    !set_trip_i [*4];
  endsequence
  logic any_on;
  assign any_on = left_top_switch_o | left_bottom_switch_o | right_top_switch_o | right_bottom_switch_o;
  // ==========================================
  // Assertions
  left_excl_a: assert property (!(left_top_switch_o && left_bottom_switch_o))
    else $error("left leg shorted");
  right_excl_a: assert property (!(right_top_switch_o && right_bottom_switch_o))
    else $error("right leg shorted");
  left_dead_a: assert property (($rose(left_top_switch_o) || $rose(left_bottom_switch_o))
    |-> $past(!left_top_switch_o && !left_bottom_switch_o)) else $error("left leg without dead time");
  right_dead_a: assert property (($rose(right_top_switch_o) || $rose(right_bottom_switch_o))
    |-> $past(!right_top_switch_o && !right_bottom_switch_o)) else $error("right leg without dead time");
  trip_flag_a: assert property (trip_held |-> !trip_n_o) else $error("trip status not shown");
  trip_off_a: assert property (trip_held |-> !any_on) else $error("switch on during trip");
  trip_stat_a: assert property (trip_held |-> !output_status_o) else $error("status on during trip");
  trip_clear_a: assert property (trip_gone |-> trip_n_o) else $error("trip status stuck");
  start_bit_a: assert property ($fell(txd_o) |-> !txd_o [*8]) else $error("start bit too short");
endmodule // spu_pwm_checker

bind spu_pwm_top spu_pwm_checker u_chk (.clk_i, .sys_rst_i, .set_trip_i, .txd_o, .left_top_switch_o,
  .left_bottom_switch_o, .right_top_switch_o, .right_bottom_switch_o, .trip_n_o, .output_status_o);
`default_nettype wire

// file: sim/spu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "spu_map.vh"
module spu_host_model (
  input wire logic clk_i,
  input wire logic txd_i,
  output var logic rxd_o
);
  // ==========================================
  // Bit timing, power-on rate first
  int div = (`SPU_CLK_HZ + `SPU_BAUD0 / 2) / `SPU_BAUD0;
  logic [7:0] rx_q[$];
  logic [7:0] b;
  initial rxd_o = 1'b1;
  task automatic send_byte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      rxd_o = f[i];
      repeat (div - 1) @(negedge clk_i);
    end
  endtask
  // Negative count sends the command byte alone
  task automatic send_block(input logic [7:0] cmd, input int n, input logic [47:0] d, input logic bad);
    logic [7:0] sum;
    sum = cmd;
    send_byte(cmd);
    for (int i = 0; i < n; i++) begin
      send_byte(d[8*i +: 8]);
      sum = sum + d[8*i +: 8];
    end
    if (n >= 0) send_byte(bad ? ~sum : sum);
  endtask
  // ==========================================
  // Receiver, mid-bit sampling
  always begin
    @(negedge txd_i);
    repeat (div / 2) @(posedge clk_i);
    if (!txd_i) begin
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk_i);
        b[i] = txd_i;
      end
      repeat (div) @(posedge clk_i);
      if (txd_i) rx_q.push_back(b);
    end
  end
endmodule // spu_host_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "spu_map.vh"
module tb;
  typedef struct {logic [7:0] cmd; int n; logic [47:0] d; logic bad; logic [7:0] rsp; logic stat;} spu_row_t;
  logic clk, sys_rst, counter_rst_n, rxd, txd, set_trip, nv_valid;
  logic [2:0] mode;
  logic [47:0] nv_init;
  logic lt, lb, rt, rb, trip_n, stat;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int w;
  spu_row_t rows [6];
  spu_pwm_top u_dut (.clk_i(clk), .sys_rst_i(sys_rst), .counter_rst_n_i(counter_rst_n), .rxd_i(rxd),
    .txd_o(txd), .set_trip_i(set_trip), .mode_select_bit2_i(mode[2]), .mode_select_bit1_i(mode[1]),
    .mode_select_bit0_i(mode[0]), .nv_valid_i(nv_valid), .nv_init_i(nv_init), .left_top_switch_o(lt),
    .left_bottom_switch_o(lb), .right_top_switch_o(rt), .right_bottom_switch_o(rb), .trip_n_o(trip_n),
    .output_status_o(stat));
  spu_host_model u_host (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  // ==========================================
  // Compare and report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reply is the code then its one-byte checksum, i.e. the same byte
  task automatic get_reply(input logic [7:0] exp);
    w = 0;
    while (u_host.rx_q.size() < 2 && w < 100000) begin
      @(negedge clk);
      w++;
    end
    chk_byte(8'(u_host.rx_q.size()), 8'h02);
    if (u_host.rx_q.size() >= 2) begin
      chk_byte(u_host.rx_q.pop_front(), exp);
      chk_byte(u_host.rx_q.pop_front(), exp);
    end
  endtask
  // ==========================================
  // Clock, timeout, sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 480000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    sys_rst = 1'b1;
    counter_rst_n = 1'b1;
    set_trip = 1'b0;
    nv_valid = 1'b0;
    nv_init = 48'h0;
    mode = `SPU_MODE_UART;
    rows[0] = '{`SPU_CMD_BR, 1, 48'h6, 1'b0, `SPU_RSP_ACK, 1'b0};
    rows[1] = '{`SPU_CMD_CTRL, 3, 48'hff_a7b8, 1'b1, `SPU_RSP_NAK, 1'b0};
    rows[2] = '{`SPU_CMD_BR, 1, 48'h7, 1'b0, `SPU_RSP_NAK, 1'b0};
    rows[3] = '{8'h33, -1, 48'h0, 1'b0, `SPU_RSP_NAK, 1'b0};
    rows[4] = '{`SPU_CMD_INIT, 6, 48'h0000_0401_3000, 1'b0, `SPU_RSP_ACK, 1'b0};
    rows[5] = '{`SPU_CMD_CTRL, 3, 48'hff_a7b8, 1'b0, `SPU_RSP_ACK, 1'b1};
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      u_host.send_block(rows[i].cmd, rows[i].n, rows[i].d, rows[i].bad);
      get_reply(rows[i].rsp);
      // New rate holds only once the reply has fully left
      if (i == 0) u_host.div = (`SPU_CLK_HZ + `SPU_BAUD6 / 2) / `SPU_BAUD6;
      repeat (5000) @(negedge clk);
      chk_bit(stat, rows[i].stat);
    end
    w = 0;
    while (!(lt | rt) && w < 20000) begin
      @(negedge clk);
      w++;
    end
    chk_bit(lt | rt, 1'b1);
    set_trip = 1'b1;
    repeat (4) @(negedge clk);
    chk_byte({trip_n, stat, 2'b00, lt, lb, rt, rb}, 8'h00);
    set_trip = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit(trip_n, 1'b1);
    // Mid-run reset drops back to inhibited outputs
    sys_rst = 1'b1;
    @(negedge clk);
    chk_byte({txd, trip_n, stat, 1'b0, lt, lb, rt, rb}, 8'hc0);
    sys_rst = 1'b0;
    repeat (10) @(negedge clk);
    chk_bit(stat, 1'b0);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
